// ### pkg/gpu_config_perf_pkg.sv
// Constants, field layouts and state type of the configuration and
// performance counter register bank.
// Assumes a 32-bit register port with byte addresses on word boundaries.
package gpu_config_perf_pkg;

    // Bank geometry
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned NUM_CTR = 16;
    localparam int unsigned SEL_W = 5;
    localparam int unsigned NUM_SRC = 30;
    localparam logic [SEL_W-1:0] SRC_LIMIT = 5'h1E;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] SCRATCH_ADDR = 9'h000;
    localparam logic [ADDR_W-1:0] IDENT0_ADDR = 9'h004;
    localparam logic [ADDR_W-1:0] CFG_A_ADDR = 9'h008;
    localparam logic [ADDR_W-1:0] CFG_B_ADDR = 9'h00C;
    localparam logic [ADDR_W-1:0] CLEAR_ADDR = 9'h010;
    localparam logic [ADDR_W-1:0] ENABLE_ADDR = 9'h014;
    localparam logic [ADDR_W-1:0] VAL_BASE = 9'h100;
    localparam logic [ADDR_W-1:0] SEL_BASE = 9'h140;

    // Identity word zero layout
    typedef struct packed {
        logic [7:0] technology_version;
        logic [23:0] block_id_string;
    } identity_zero_t;

    // Configuration word A layout
    typedef struct packed {
        logic [3:0] vertex_memory_size;
        logic [3:0] high_range_support;
        logic [7:0] semaphore_count;
        logic [3:0] texture_units_per_slice;
        logic [3:0] shader_procs_per_slice;
        logic [3:0] slice_count;
        logic [3:0] hardware_revision;
    } config_a_t;

    // Configuration word B layout, top bits reserved
    typedef struct packed {
        logic [19:0] reserved;
        logic [3:0] tile_buffer_double_support;
        logic [3:0] tile_buffer_size;
        logic [3:0] aux_memory_size;
    } config_b_t;

    // Version and id string codes are arbitrary values
    localparam identity_zero_t IDENT0 = '{8'h5A, 24'hA5C3E1};
    // Build configuration, revision code arbitrary; size 0 means 16K
    localparam config_a_t CONFIG_A = '{4'hC, 4'h1, 8'h10, 4'h2, 4'h4, 4'h3, 4'h7};
    // Tile buffer 0 quarter, 1 half, 2 full; aux 0 half, 1 full
    localparam config_b_t CONFIG_B = '{20'h00000, 4'h1, 4'h2, 4'h1};

    // Event source identifiers
    localparam logic [SEL_W-1:0] SRC_FE_NO_PIXEL = 5'h00;
    localparam logic [SEL_W-1:0] SRC_FE_TILE_PRIM = 5'h01;
    localparam logic [SEL_W-1:0] SRC_TB_QUAD_WRITTEN = 5'h09;
    localparam logic [SEL_W-1:0] SRC_SP_IDLE = 5'h0D;
    localparam logic [SEL_W-1:0] SRC_L2_MISS = 5'h1D;

    // Whole register bank state
    typedef struct packed {
        logic [31:0] scratch;
        logic [NUM_CTR-1:0] ctr_en;
        logic [NUM_CTR-1:0][SEL_W-1:0] ctr_sel;
        logic [NUM_CTR-1:0][31:0] ctr_val;
        logic [31:0] rdata;
    } bank_state_t;

endpackage : gpu_config_perf_pkg

// ### rtl/gpu_config_perf_regs.sv
// Scratch, identity and performance counter register bank.
// Assumes a single-cycle register port and one-cycle event pulses,
// all synchronous to sys_clk_i.
// Identity words are build constants; nothing here can alter them.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

// Functional notes
// - Scratch word read/write, resets zero, no effects
// - Identity words read-only, writes ignored
// - Identity zero top byte: technology version
// - Identity zero low 24 bits: id string
// - Config A 31:28 vertex memory size, 0=16K
// - Config A 27:24 high range support flag
// - Config A semaphores 23:16, texture units 15:12
// - Config A processors, slices, revision fields
// - Config B 11:8 double buffer, top reserved
// - Config B tile size and aux memory codes
// - Sixteen counters, each maps one of thirty
// - Sources 0-3 are front-end events
// - Sources 4-9 are tile buffer quad events
// - Sources 10-12 count discarded or clipped primitives
// - Sources 13-19 count shader processor cycles
// - Sources 20-23 count instruction/uniform cache hits, misses
// - Source 24 texture quads, 25 texture misses
// - Sources 26-27 count vertex memory stall cycles
// - Sources 28-29 count second-level cache hits, misses
// - Enable bit: count when set, hold otherwise
// - Writing one to clear bit zeroes counter
// - Counter value 32-bit read/write, resets zero
// - Five-bit source select per counter, resets zero
module gpu_config_perf_regs (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [8:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [29:0] event_i,
    output logic [31:0] rdata_o
);

    // Registered state and its next value
    gpu_config_perf_pkg::bank_state_t st;
    gpu_config_perf_pkg::bank_state_t next_st;

    // Selected event per counter, shared by counting and checks
    logic [15:0] ev_sel;

    // Summed sources arrive already reduced to one pulse per cycle
    // Event bit of a source, zero for undefined ids
    function automatic logic src_hit(input logic [4:0] sel, input logic [29:0] ev);
        logic hit;
        hit = 1'b0;
        // Ids 30 and 31 have no event behind them
        if (sel < gpu_config_perf_pkg::SRC_LIMIT) begin
            hit = ev[sel];
        end
        return hit;
    endfunction : src_hit

    // Low two address bits must be zero; misaligned offsets alias nothing
    // Address falls in the counter value window
    function automatic logic hit_val(input logic [8:0] a);
        return (a[8:6] == gpu_config_perf_pkg::VAL_BASE[8:6]) && (a[1:0] == 2'h0);
    endfunction : hit_val

    // Address falls in the source select window
    function automatic logic hit_sel(input logic [8:0] a);
        return (a[8:6] == gpu_config_perf_pkg::SEL_BASE[8:6]) && (a[1:0] == 2'h0);
    endfunction : hit_sel

    // Counter index within either window
    function automatic logic [3:0] ctr_idx(input logic [8:0] a);
        return a[5:2];
    endfunction : ctr_idx

    // Read multiplexer; unmapped addresses read zero
    function automatic logic [31:0] read_word(
        input gpu_config_perf_pkg::bank_state_t s,
        input logic [8:0] a
    );
        logic [31:0] w;
        w = 32'h0;
        if (a == gpu_config_perf_pkg::SCRATCH_ADDR) begin
            w = s.scratch;
        end else if (a == gpu_config_perf_pkg::IDENT0_ADDR) begin
            // Fixed version and id string
            w = gpu_config_perf_pkg::IDENT0;
        end else if (a == gpu_config_perf_pkg::CFG_A_ADDR) begin
            // Build configuration fields
            w = gpu_config_perf_pkg::CONFIG_A;
        end else if (a == gpu_config_perf_pkg::CFG_B_ADDR) begin
            // Reserved top bits read zero
            w = gpu_config_perf_pkg::CONFIG_B;
        end else if (a == gpu_config_perf_pkg::ENABLE_ADDR) begin
            w = {16'h0, s.ctr_en};
        end else if (hit_val(a)) begin
            w = s.ctr_val[ctr_idx(a)];
        end else if (hit_sel(a)) begin
            w = {27'h0, s.ctr_sel[ctr_idx(a)]};
        end
        // Clear register is write-only and reads zero
        return w;
    endfunction : read_word

    // Event selection per counter
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            ev_sel[i] = src_hit(st.ctr_sel[i], event_i);
        end
    end

    // Enable and select changes act from the next edge on
    // Next state: read capture, counting, then software writes
    always_comb begin
        next_st = st;
        // Read data stands for one cycle only
        next_st.rdata = 32'h0;
        // Read samples the state before this edge's update
        if (rd_i) begin
            next_st.rdata = read_word(st, addr_i);
        end
        // Counting; event identifiers map straight onto event_i bits
        // A counter wraps to zero past all ones
        for (int i = 0; i < 16; i++) begin
            if (st.ctr_en[i] && ev_sel[i]) begin
                next_st.ctr_val[i] = st.ctr_val[i] + 32'h1;
            end
        end
        // Software writes override counting in the same cycle
        if (wr_i) begin
            if (addr_i == gpu_config_perf_pkg::SCRATCH_ADDR) begin
                // Plain storage, steers nothing
                next_st.scratch = wdata_i;
            end else if (addr_i == gpu_config_perf_pkg::ENABLE_ADDR) begin
                next_st.ctr_en = wdata_i[15:0];
            end else if (addr_i == gpu_config_perf_pkg::CLEAR_ADDR) begin
                // Only bits written as one clear
                for (int i = 0; i < 16; i++) begin
                    if (wdata_i[i]) begin
                        next_st.ctr_val[i] = 32'h0;
                    end
                end
            end else if (hit_val(addr_i)) begin
                next_st.ctr_val[ctr_idx(addr_i)] = wdata_i;
            end else if (hit_sel(addr_i)) begin
                next_st.ctr_sel[ctr_idx(addr_i)] = wdata_i[4:0];
            end
            // Identity words and unmapped addresses ignore writes
        end
    end

    // State register, cleared to zero by reset
    // Whole state clears together; no field resets nonzero
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Read data straight from the state register
    assign rdata_o = st.rdata;

    // Checks share one clock and reset
    // Nothing is checked while reset is held
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Scratch keeps its value unless written
    a_scratch_keep: assert property (
        !(wr_i && addr_i == gpu_config_perf_pkg::SCRATCH_ADDR) |=> $stable(st.scratch)
    ) else $error("scratch changed without a write");

    // Scratch write read back two cycles on
    a_scratch_back: assert property (
        (wr_i && addr_i == gpu_config_perf_pkg::SCRATCH_ADDR)
        ##1 (rd_i && addr_i == gpu_config_perf_pkg::SCRATCH_ADDR)
        |=> rdata_o == $past(wdata_i, 2)
    ) else $error("scratch read back wrong");

    // Write to a config word then read is unchanged
    a_ident_ro: assert property (
        (wr_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        ##1 (rd_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        |=> rdata_o == 32'(gpu_config_perf_pkg::CONFIG_A)
    ) else $error("config word A altered by write");

    // Technology version byte
    a_tech_version: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::IDENT0_ADDR)
        |=> rdata_o[31:24] == gpu_config_perf_pkg::IDENT0.technology_version
    ) else $error("technology version wrong");

    // Id string bytes
    a_id_string: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::IDENT0_ADDR)
        |=> rdata_o[23:0] == gpu_config_perf_pkg::IDENT0.block_id_string
    ) else $error("id string wrong");

    // Vertex memory size field
    a_vpm_size: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        |=> rdata_o[31:28] == gpu_config_perf_pkg::CONFIG_A.vertex_memory_size
    ) else $error("vertex memory size wrong");

    // High range support field
    a_range_flag: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        |=> rdata_o[27:24] == gpu_config_perf_pkg::CONFIG_A.high_range_support
    ) else $error("high range flag wrong");

    // Semaphore and texture unit counts
    a_sem_tex: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        |=> rdata_o[23:12] == {gpu_config_perf_pkg::CONFIG_A.semaphore_count,
                               gpu_config_perf_pkg::CONFIG_A.texture_units_per_slice}
    ) else $error("semaphore or texture count wrong");

    // Processors, slices and revision
    a_proc_slice: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_A_ADDR)
        |=> rdata_o[11:0] == 12'(gpu_config_perf_pkg::CONFIG_A)
    ) else $error("processor, slice or revision wrong");

    // Double buffer flag and reserved bits
    a_cfg_b_top: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_B_ADDR)
        |=> rdata_o[31:8] == {20'h0, gpu_config_perf_pkg::CONFIG_B.tile_buffer_double_support}
    ) else $error("config B upper bits wrong");

    // Tile size and aux memory codes
    a_cfg_b_low: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CFG_B_ADDR)
        |=> rdata_o[7:0] == {gpu_config_perf_pkg::CONFIG_B.tile_buffer_size,
                             gpu_config_perf_pkg::CONFIG_B.aux_memory_size}
    ) else $error("config B lower bits wrong");

    // Identity word zero unchanged by a write
    a_ident0_ro: assert property (
        (wr_i && addr_i == gpu_config_perf_pkg::IDENT0_ADDR)
        ##1 (rd_i && addr_i == gpu_config_perf_pkg::IDENT0_ADDR)
        |=> rdata_o == 32'(gpu_config_perf_pkg::IDENT0)
    ) else $error("identity word zero altered by write");

    // Config word B unchanged by a write
    a_cfg_b_ro: assert property (
        (wr_i && addr_i == gpu_config_perf_pkg::CFG_B_ADDR)
        ##1 (rd_i && addr_i == gpu_config_perf_pkg::CFG_B_ADDR)
        |=> rdata_o == 32'(gpu_config_perf_pkg::CONFIG_B)
    ) else $error("config word B altered by write");

    // Clear register is write-only and reads zero
    a_clear_reads_zero: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::CLEAR_ADDR) |=> rdata_o == 32'h0
    ) else $error("clear register read nonzero");

    // Enable write loads the low sixteen bits
    a_en_load: assert property (
        (wr_i && addr_i == gpu_config_perf_pkg::ENABLE_ADDR)
        |=> st.ctr_en == $past(wdata_i[15:0])
    ) else $error("enable bits not loaded");

    // Enable bits hold unless written
    a_en_keep: assert property (
        !(wr_i && addr_i == gpu_config_perf_pkg::ENABLE_ADDR) |=> $stable(st.ctr_en)
    ) else $error("enable bits changed without a write");

    // Enable read returns the bits, upper half zero
    a_en_read: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::ENABLE_ADDR)
        |=> rdata_o == {16'h0, $past(st.ctr_en)}
    ) else $error("enable read back wrong");

    // Scratch read returns the stored word
    a_scratch_read: assert property (
        (rd_i && addr_i == gpu_config_perf_pkg::SCRATCH_ADDR) |=> rdata_o == $past(st.scratch)
    ) else $error("scratch read wrong");

    // Per-counter checks
    for (genvar g = 0; g < 16; g++) begin : g_ctr_chk
        // A select write leaves this counter's count alone
        // Software touches this counter's value this cycle
        logic touch;
        assign touch = wr_i && ((hit_val(addr_i) && ctr_idx(addr_i) == 4'(g))
            || (addr_i == gpu_config_perf_pkg::CLEAR_ADDR && wdata_i[g]));

        // Enabled with event present: plus one
        a_ctr_count: assert property (
            (!touch && st.ctr_en[g] && ev_sel[g])
            |=> st.ctr_val[g] == $past(st.ctr_val[g]) + 32'h1
        ) else $error("counter failed to increment");

        // Counter disabled two cycles in a row holds over the second
        a_ctr_hold: assert property (
            (!touch && !st.ctr_en[g]) [*2] |=> $stable(st.ctr_val[g])
        ) else $error("disabled counter moved");

        // Increment equals the selected event bit
        a_src_map: assert property (
            (!touch && st.ctr_en[g])
            |=> st.ctr_val[g] - $past(st.ctr_val[g]) == {31'h0, $past(ev_sel[g])}
        ) else $error("counter not following its source");

        // Clear bit zeroes the counter
        a_ctr_clear: assert property (
            (wr_i && addr_i == gpu_config_perf_pkg::CLEAR_ADDR && wdata_i[g])
            |=> st.ctr_val[g] == 32'h0
        ) else $error("counter not cleared");

        // Value write loads the written word
        a_ctr_load: assert property (
            (wr_i && hit_val(addr_i) && ctr_idx(addr_i) == 4'(g))
            |=> st.ctr_val[g] == $past(wdata_i)
        ) else $error("counter value not loaded");

        // Source select write
        a_sel_load: assert property (
            (wr_i && hit_sel(addr_i) && ctr_idx(addr_i) == 4'(g))
            |=> st.ctr_sel[g] == $past(wdata_i[4:0])
        ) else $error("source select not loaded");

        // Undefined sources never count
        a_src_undef: assert property (
            (!touch && st.ctr_sel[g] >= gpu_config_perf_pkg::SRC_LIMIT) |=> $stable(st.ctr_val[g])
        ) else $error("undefined source counted");

        // Select keeps its value unless written
        a_sel_keep: assert property (
            !(wr_i && hit_sel(addr_i) && ctr_idx(addr_i) == 4'(g)) |=> $stable(st.ctr_sel[g])
        ) else $error("source select changed without a write");

        // Undefined sources never raise the selected event
        a_undef_no_hit: assert property (
            (st.ctr_sel[g] >= gpu_config_perf_pkg::SRC_LIMIT) |-> !ev_sel[g]
        ) else $error("undefined source selected an event");

        // Count read returns the value before this cycle's update
        a_val_read: assert property (
            (rd_i && hit_val(addr_i) && ctr_idx(addr_i) == 4'(g))
            |=> rdata_o == $past(st.ctr_val[g])
        ) else $error("count read back wrong");

        // Select read returns the field, upper bits zero
        a_sel_read: assert property (
            (rd_i && hit_sel(addr_i) && ctr_idx(addr_i) == 4'(g))
            |=> rdata_o == {27'h0, $past(st.ctr_sel[g])}
        ) else $error("source select read back wrong");
    end

    // Scenario covers for L2 counting, busy clear, identity-then-counter read, undefined source and wrap

    // Counter 13 counting second-level cache misses
    c_l2_count: cover property (
        st.ctr_en[13] && st.ctr_sel[13] == gpu_config_perf_pkg::SRC_L2_MISS && event_i[29]
    );

    // Clear during active counting
    c_clear_busy: cover property (
        wr_i && addr_i == gpu_config_perf_pkg::CLEAR_ADDR && st.ctr_en[0] && ev_sel[0]
    );

    // Identity read followed by counter read
    c_id_then_ctr: cover property (
        (rd_i && addr_i == gpu_config_perf_pkg::IDENT0_ADDR) ##1 (rd_i && hit_val(addr_i))
    );

    // Enabled counter on an undefined source while events fire
    c_undef_busy: cover property (
        st.ctr_en[14] && st.ctr_sel[14] == gpu_config_perf_pkg::SRC_LIMIT && event_i != 30'h0
    );

    // Counter 5 wrapping from all ones
    c_count_wrap: cover property (
        st.ctr_en[5] && st.ctr_val[5] == 32'hFFFFFFFF && ev_sel[5]
    );

endmodule : gpu_config_perf_regs

// ### testbench/tb.sv
// Self-checking bench for the scratch, identity and counter register bank.
// Assumes the bank package and the bank module are compiled before it.
`timescale 1ns/1ns
module tb;
    logic sys_clk_i = 1'b0; // Bench clock
    logic rst_n_i = 1'b0; // Active-low reset
    logic [8:0] addr_i = 9'h000; // Register address
    logic [31:0] wdata_i = 32'h00000000; // Write data
    logic wr_i = 1'b0; // Write strobe
    logic rd_i = 1'b0; // Read strobe
    logic [29:0] event_i = 30'h00000000; // Event pulses
    logic [31:0] rdata_o; // Read data
    logic rd_q = 1'b0; // Read taken at last edge
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    logic [31:0] a; // Random words
    logic [31:0] b;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0; // Hang guard

    gpu_config_perf_regs i_gpu_config_perf_regs (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .event_i(event_i),
        .rdata_o(rdata_o)
    );

    // Clock at 50 MHz
    always #10 sys_clk_i = ~sys_clk_i;

    // Compare one value, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: read 0x%08h, expected 0x%08h", $time, seen, exp);
        end
    endtask : check

    // Counts, verdict and end of run
    task automatic print_verdict();
        // A read whose data never appeared counts as a mismatch
        if (exp_q.size() != 0) begin
            error_cnt++;
        end
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // One bus cycle; every strobe set once per edge
    task automatic bus(input logic w, input logic r, input logic [8:0] ad, input logic [31:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= ad;
        wdata_i <= d;
        @(posedge sys_clk_i);
    endtask : bus

    task automatic wr(input logic [8:0] ad, input logic [31:0] d);
        bus(1'b1, 1'b0, ad, d);
    endtask : wr

    // Read with its expectation noted first
    task automatic rd(input logic [8:0] ad, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, ad, 32'h00000000);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 9'h000, 32'h00000000);
    endtask : idle

    function automatic logic [8:0] val_addr(input int n);
        return gpu_config_perf_pkg::VAL_BASE + 9'(4 * n);
    endfunction : val_addr

    function automatic logic [8:0] sel_addr(input int n);
        return gpu_config_perf_pkg::SEL_BASE + 9'(4 * n);
    endfunction : sel_addr

    // Map one source, count random pulses, then hold while disabled
    task automatic count_src(input int src);
        int n;
        logic [29:0] ev;
        logic [31:0] cnt;
        n = src % 16;
        cnt = 32'h00000000;
        wr(sel_addr(n), 32'(src));
        wr(gpu_config_perf_pkg::CLEAR_ADDR, 32'h00000001 << n);
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000001 << n);
        repeat (1 + $urandom % 8) begin
            ev = 30'($urandom);
            if (src < 30 && ev[src % 30]) cnt++;
            event_i <= ev;
            idle(1);
        end
        event_i <= 30'h00000000;
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        repeat (3) begin
            event_i <= 30'($urandom);
            idle(1);
        end
        event_i <= 30'h00000000;
        rd(val_addr(n), cnt);
        rd(sel_addr(n), 32'(src));
    endtask : count_src

    // Read data checker: one note per read, zero between reads
    always @(posedge sys_clk_i) rd_q <= rd_i;
    always @(negedge sys_clk_i) begin
        if (rd_q) begin
            check(rdata_o, exp_q.pop_front());
        end else if (rst_n_i) begin
            check(rdata_o, 32'h00000000);
        end
    end

    // Hang guard, far above the expected run length
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'hE1DFC530));
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        // Reset values
        rd(gpu_config_perf_pkg::SCRATCH_ADDR, 32'h00000000);
        rd(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        for (int n = 0; n < 16; n++) begin
            rd(val_addr(n), 32'h00000000);
            rd(sel_addr(n), 32'h00000000);
        end
        // Scratch back to back, unmapped writes leave it alone
        a = $urandom;
        wr(gpu_config_perf_pkg::SCRATCH_ADDR, a);
        rd(gpu_config_perf_pkg::SCRATCH_ADDR, a);
        wr(9'h018, $urandom);
        wr(9'h001, $urandom);
        rd(gpu_config_perf_pkg::SCRATCH_ADDR, a);
        rd(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        rd(9'h018, 32'h00000000);
        rd(9'h1FC, 32'h00000000);
        // Identity words ignore writes, each read right after its write
        wr(gpu_config_perf_pkg::IDENT0_ADDR, $urandom);
        rd(gpu_config_perf_pkg::IDENT0_ADDR, 32'(gpu_config_perf_pkg::IDENT0));
        wr(gpu_config_perf_pkg::CFG_A_ADDR, $urandom);
        rd(gpu_config_perf_pkg::CFG_A_ADDR, 32'(gpu_config_perf_pkg::CONFIG_A));
        wr(gpu_config_perf_pkg::CFG_B_ADDR, $urandom);
        rd(gpu_config_perf_pkg::CFG_B_ADDR, {20'h00000, 12'h121});
        // Enable readback, upper half reads zero
        a = $urandom;
        wr(gpu_config_perf_pkg::ENABLE_ADDR, a);
        rd(gpu_config_perf_pkg::ENABLE_ADDR, {16'h0000, a[15:0]});
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        // Clear hits only the selected counter
        a = $urandom;
        b = $urandom;
        wr(val_addr(3), a);
        wr(val_addr(4), b);
        rd(val_addr(3), a);
        wr(gpu_config_perf_pkg::CLEAR_ADDR, 32'h00000008);
        rd(val_addr(3), 32'h00000000);
        rd(val_addr(4), b);
        rd(gpu_config_perf_pkg::CLEAR_ADDR, 32'h00000000);
        // Every source id, including the two undefined ones
        for (int s = 0; s < 32; s++) begin
            count_src(s);
        end
        // Count wraps past all ones
        wr(val_addr(5), 32'hFFFFFFFF);
        wr(sel_addr(5), 32'h00000000);
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000020);
        event_i <= 30'h00000001;
        idle(1);
        event_i <= 30'h00000000;
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        rd(val_addr(5), 32'h00000000);
        // Clear and value write beat a same-cycle increment
        wr(sel_addr(0), 32'(gpu_config_perf_pkg::SRC_FE_NO_PIXEL));
        wr(gpu_config_perf_pkg::CLEAR_ADDR, 32'h00000001);
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000001);
        event_i <= 30'h00000001;
        wr(gpu_config_perf_pkg::CLEAR_ADDR, 32'h00000001);
        rd(val_addr(0), 32'h00000000);
        wr(val_addr(0), 32'h00000010);
        event_i <= 30'h00000000;
        wr(gpu_config_perf_pkg::ENABLE_ADDR, 32'h00000000);
        rd(val_addr(0), 32'h00000010);
        idle(2);
        print_verdict();
    end
endmodule : tb
